// ### pkg/c16_regs.vh
// register map and timing constants for the serial-reload 16-bit counter
`ifndef C16_REGS_VH
`define C16_REGS_VH

// ====================================================================
// register byte addresses, counter block zero
`define C16_ADDR_RELOAD_LO 8'hC5
`define C16_ADDR_RELOAD_HI 8'hC6
`define C16_ADDR_LIVE_LO 8'hEB
`define C16_ADDR_LIVE_HI 8'hEC

// ====================================================================
// reset values and counter end/step constants
`define C16_RELOAD_RST 16'h0000
`define C16_COUNT_RST 16'h0000
`define C16_ZERO 16'h0000
`define C16_ONE 16'h0001
`define C16_ALL_ONES 16'hFFFF

// ====================================================================
// hold window: 2 * 9 serial clock periods
`define C16_HOLD_BITS 18
`define C16_ARM_EDGES 2'h2

`endif

// ### verilog/c16_serial_target.v
// serial register target: byte-oriented target with word address and auto increment
`timescale 1ns/1ps
`default_nettype none
`include "c16_regs.vh"

module c16_serial_target #(
    parameter [6:0] TARGET_ADDR = 7'h08
) (
    // clock and reset
    input wire core_clk,
    input wire reset,
    // serial pins, sampled synchronously
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    // register side
    output reg [7:0] word_addr_r,
    output reg addr_strobe_r,
    output reg [7:0] wr_data_r,
    output reg wr_strobe_r,
    output reg rd_strobe_r,
    input wire [7:0] rd_data,
    output reg rd_phase_r,
    output reg scl_rise_r
);

    // ================================================================
    // edge and condition detection
    localparam S_IDLE = 5'b00001;
    localparam S_DEV = 5'b00010;
    localparam S_WADDR = 5'b00100;
    localparam S_WDATA = 5'b01000;
    localparam S_RDATA = 5'b10000;

    reg scl_d_r;
    reg sda_d_r;
    reg [4:0] state_r;
    reg [3:0] bit_cnt_r;
    reg [7:0] shift_r;
    reg ack_r;
    reg drive_r;
    reg first_r;

    wire scl_rise = scl_in & ~scl_d_r;
    wire scl_fall = ~scl_in & scl_d_r;
    wire start_c = scl_in & scl_d_r & sda_d_r & ~sda_in;
    wire stop_c = scl_in & scl_d_r & ~sda_d_r & sda_in;

    // open-drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = drive_r;

    always @(posedge core_clk) begin
        if (reset) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            state_r <= S_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            ack_r <= 1'b0;
            drive_r <= 1'b0;
            first_r <= 1'b0;
            word_addr_r <= 8'h00;
            addr_strobe_r <= 1'b0;
            wr_data_r <= 8'h00;
            wr_strobe_r <= 1'b0;
            rd_strobe_r <= 1'b0;
            rd_phase_r <= 1'b0;
            scl_rise_r <= 1'b0;
        end else begin
            scl_d_r <= scl_in;
            sda_d_r <= sda_in;
            addr_strobe_r <= 1'b0;
            wr_strobe_r <= 1'b0;
            rd_strobe_r <= 1'b0;
            scl_rise_r <= scl_rise;
            if (start_c) begin
                state_r <= S_DEV;
                bit_cnt_r <= 4'h0;
                ack_r <= 1'b0;
                drive_r <= 1'b0;
                rd_phase_r <= 1'b0;
            end else if (stop_c) begin
                state_r <= S_IDLE;
                drive_r <= 1'b0;
                rd_phase_r <= 1'b0;
            end else if (state_r != S_IDLE) begin
                if (scl_rise && !ack_r) begin
                    shift_r <= {shift_r[6:0], sda_in};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
                if (scl_fall) begin
                    if (ack_r) begin
                        // acknowledge slot over: release, then move on
                        ack_r <= 1'b0;
                        drive_r <= 1'b0;
                        bit_cnt_r <= 4'h0;
                        if (state_r == S_RDATA) begin
                            drive_r <= ~rd_data[7];
                            shift_r <= rd_data;
                        end
                    end else if (bit_cnt_r == 4'h8) begin
                        case (state_r)
                            S_DEV: begin
                                if (shift_r[7:1] == TARGET_ADDR) begin
                                    ack_r <= 1'b1;
                                    drive_r <= 1'b1;
                                    if (shift_r[0]) begin
                                        state_r <= S_RDATA;
                                        rd_phase_r <= 1'b1;
                                        rd_strobe_r <= 1'b1;
                                        ack_r <= 1'b1;
                                    end else begin
                                        state_r <= S_WADDR;
                                    end
                                end else begin
                                    state_r <= S_IDLE;
                                end
                            end
                            S_WADDR: begin
                                word_addr_r <= shift_r;
                                addr_strobe_r <= 1'b1;
                                ack_r <= 1'b1;
                                drive_r <= 1'b1;
                                state_r <= S_WDATA;
                                first_r <= 1'b1;
                            end
                            S_WDATA: begin
                                wr_data_r <= shift_r;
                                wr_strobe_r <= 1'b1;
                                ack_r <= 1'b1;
                                drive_r <= 1'b1;
                            end
                            S_RDATA: begin
                                // host acknowledge is sampled on the next rise
                                drive_r <= 1'b0;
                                bit_cnt_r <= 4'h9;
                            end
                            default: state_r <= S_IDLE;
                        endcase
                    end else if (state_r == S_RDATA && bit_cnt_r < 4'h8) begin
                        // the rise has already moved the next bit to the top
                        drive_r <= ~shift_r[7];
                    end else if (state_r == S_RDATA && bit_cnt_r == 4'hA) begin
                        // host ack low means another byte
                        if (!shift_r[0]) begin
                            rd_strobe_r <= 1'b1;
                            ack_r <= 1'b1;
                        end else begin
                            state_r <= S_IDLE;
                            rd_phase_r <= 1'b0;
                        end
                    end
                end
                if (wr_strobe_r || (rd_strobe_r && !first_r))
                    word_addr_r <= word_addr_r + 8'h01;
                if (rd_strobe_r)
                    first_r <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ### verilog/c16_counter.v
// 16-bit counter with serial-reachable reload and live-count registers
`timescale 1ns/1ps
`default_nettype none
`include "c16_regs.vh"

module c16_counter #(
    parameter WIDTH = 16,
    parameter HOLD_BITS = `C16_HOLD_BITS,
    parameter [6:0] TARGET_ADDR = 7'h08
) (
    // clock and reset
    input wire core_clk,
    input wire reset,
    // counter control, synchronous to core_clk
    input wire cnt_clk_in,
    input wire cnt_set,
    input wire cnt_reset,
    input wire count_up,
    input wire hold_enable,
    // serial target pins
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    // outputs
    output reg cnt_out_r,
    output reg [WIDTH-1:0] live_count_r,
    output reg hold_active_r
);

    // ================================================================
    // serial target
    wire [7:0] word_addr;
    wire addr_strobe;
    wire [7:0] wr_data;
    wire wr_strobe;
    wire rd_strobe;
    wire rd_phase;
    wire scl_rise;
    reg [7:0] rd_data_r;

    c16_serial_target #(
        .TARGET_ADDR(TARGET_ADDR)
    ) u_target (
        .core_clk(core_clk),
        .reset(reset),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .word_addr_r(word_addr),
        .addr_strobe_r(addr_strobe),
        .wr_data_r(wr_data),
        .wr_strobe_r(wr_strobe),
        .rd_strobe_r(rd_strobe),
        .rd_data(rd_data_r),
        .rd_phase_r(rd_phase),
        .scl_rise_r(scl_rise)
    );

    // ================================================================
    // address decode
    function is_reload_addr;
        input [7:0] a;
        begin
            is_reload_addr = (a == `C16_ADDR_RELOAD_LO) || (a == `C16_ADDR_RELOAD_HI);
        end
    endfunction

    // ================================================================
    // reload register, byte-wise
    reg [WIDTH-1:0] reload_r;

    always @(posedge core_clk) begin
        if (reset) begin
            reload_r <= `C16_RELOAD_RST;
        end else if (wr_strobe) begin
            // each byte lands on its own strobe, so low-then-high
            // writes leave a mixed value in between
            if (word_addr == `C16_ADDR_RELOAD_LO)
                reload_r[7:0] <= wr_data;
            else if (word_addr == `C16_ADDR_RELOAD_HI)
                reload_r[WIDTH-1:8] <= wr_data[WIDTH-9:0];
        end
    end

    // read mux, captured at each read strobe
    always @(posedge core_clk) begin
        if (reset) begin
            rd_data_r <= 8'h00;
        end else if (rd_strobe) begin
            case (word_addr)
                `C16_ADDR_RELOAD_LO: rd_data_r <= reload_r[7:0];
                `C16_ADDR_RELOAD_HI: rd_data_r <= reload_r[WIDTH-1:8];
                `C16_ADDR_LIVE_LO: rd_data_r <= live_count_r[7:0];
                `C16_ADDR_LIVE_HI: rd_data_r <= live_count_r[WIDTH-1:8];
                default: rd_data_r <= 8'h00;
            endcase
        end
    end

    // ================================================================
    // clock hold window, counted in serial clock rises
    reg [4:0] hold_cnt_r;
    reg rd_reload_r;

    always @(posedge core_clk) begin
        if (reset) begin
            hold_cnt_r <= 5'h00;
            hold_active_r <= 1'b0;
            rd_reload_r <= 1'b0;
        end else begin
            // address match alone triggers, so reads and writes both hold
            if (addr_strobe && hold_enable && is_reload_addr(word_addr)) begin
                hold_active_r <= 1'b1;
                hold_cnt_r <= HOLD_BITS[4:0];
            end else if (hold_active_r && scl_rise) begin
                if (hold_cnt_r == 5'h01)
                    hold_active_r <= 1'b0;
                hold_cnt_r <= hold_cnt_r - 5'h01;
            end
            if (rd_strobe)
                rd_reload_r <= is_reload_addr(word_addr);
            if (!rd_phase)
                rd_reload_r <= 1'b0;
        end
    end

    // ================================================================
    // counter chain
    reg clk_d_r;
    reg [1:0] arm_cnt_r;
    reg armed_r;
    wire clk_rise = cnt_clk_in & ~clk_d_r;
    wire clk_fall = ~cnt_clk_in & clk_d_r;
    // hold gates only when enabled; otherwise clock passes untouched
    wire clk_tick = clk_rise & ~(hold_enable & hold_active_r);
    wire at_end = count_up ? (live_count_r == `C16_ALL_ONES) : (live_count_r == `C16_ZERO);

    always @(posedge core_clk) begin
        if (reset) begin
            clk_d_r <= 1'b0;
            live_count_r <= `C16_COUNT_RST;
            cnt_out_r <= 1'b0;
            armed_r <= 1'b0;
            arm_cnt_r <= 2'h0;
        end else begin
            clk_d_r <= cnt_clk_in;
            cnt_out_r <= 1'b0;
            if (cnt_reset) begin
                live_count_r <= `C16_COUNT_RST;
                armed_r <= 1'b0;
                arm_cnt_r <= 2'h0;
            end else if (cnt_set) begin
                live_count_r <= reload_r;
                armed_r <= 1'b0;
                arm_cnt_r <= 2'h0;
            end else begin
                // known quirk kept on purpose: a falling edge while
                // reload bytes are returned arms an unexpected load
                if (clk_fall && rd_reload_r && !armed_r) begin
                    armed_r <= 1'b1;
                    arm_cnt_r <= 2'h0;
                end
                if (clk_tick) begin
                    if (armed_r && arm_cnt_r + 2'h1 == `C16_ARM_EDGES) begin
                        live_count_r <= reload_r;
                        armed_r <= 1'b0;
                        arm_cnt_r <= 2'h0;
                    end else begin
                        if (armed_r)
                            arm_cnt_r <= arm_cnt_r + 2'h1;
                        if (at_end) begin
                            // reload uses the register as it stands now
                            live_count_r <= reload_r;
                            cnt_out_r <= 1'b1;
                        end else if (count_up) begin
                            live_count_r <= live_count_r + `C16_ONE;
                        end else begin
                            live_count_r <= live_count_r - `C16_ONE;
                        end
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire

// ### test/c16_counter_assertions.sv
// port-level assertions for the serial-reload counter
`timescale 1ns/1ps
`default_nettype none
module c16_counter_assertions #(
    parameter WIDTH = 16,
    parameter HOLD_BITS = 18
) (
    // clock, reset and counter control
    input wire logic core_clk,
    input wire logic reset,
    input wire logic cnt_clk_in,
    input wire logic cnt_set,
    input wire logic cnt_reset,
    input wire logic count_up,
    input wire logic hold_enable,
    // serial clock and outputs
    input wire logic scl_in,
    input wire logic cnt_out_r,
    input wire logic [WIDTH-1:0] live_count_r,
    input wire logic hold_active_r
);
    logic scl_q;
    logic [3:0] clk_h;
    logic [7:0] rises_r;
    wire quiet = !cnt_set && !cnt_reset;
    // ================================================================
    // helpers: counter clock history, serial rises inside the hold window
    always_ff @(posedge core_clk) begin
        scl_q <= scl_in;
        clk_h <= {clk_h[2:0], cnt_clk_in};
        if (reset || !hold_active_r) begin
            rises_r <= 8'h00;
        end else if (scl_in && !scl_q) begin
            rises_r <= rises_r + 8'h01;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // ================================================================
    // checks
    a_pulse_single: assert property (cnt_out_r |=> !cnt_out_r)
        else $error("counter pulse longer than one cycle");
    a_pulse_at_end: assert property (cnt_out_r |->
        $past(live_count_r) == {WIDTH{$past(count_up)}})
        else $error("counter pulse without underflow or overflow");
    a_clear_count: assert property (cnt_reset |=> live_count_r == '0)
        else $error("counter reset did not clear the count");
    a_down_step: assert property ($changed(live_count_r) && !cnt_out_r &&
        !$past(count_up) && $past(quiet) && $past(quiet, 2) && !$past(reset)
        |-> live_count_r == $past(live_count_r) - 1'h1)
        else $error("down count did not step by one");
    a_edge_needed: assert property ($changed(live_count_r) && $past(quiet) &&
        $past(quiet, 2) && !$past(reset) |-> |(clk_h[2:0] & ~clk_h[3:1]))
        else $error("count moved without a counter clock rise");
    a_hold_freeze: assert property (hold_enable && hold_active_r &&
        $past(hold_active_r) && $past(hold_enable) && quiet |=> $stable(live_count_r))
        else $error("count moved inside the hold window");
    a_hold_enabled: assert property ($rose(hold_active_r) |-> $past(hold_enable))
        else $error("hold window opened while the feature is off");
    a_hold_window: assert property (rises_r <= HOLD_BITS)
        else $error("hold window outlasted its serial clock count");
endmodule
bind c16_counter c16_counter_assertions #(.WIDTH(WIDTH), .HOLD_BITS(HOLD_BITS)) u_chk (
    .core_clk(core_clk), .reset(reset), .cnt_clk_in(cnt_clk_in), .cnt_set(cnt_set),
    .cnt_reset(cnt_reset), .count_up(count_up), .hold_enable(hold_enable),
    .scl_in(scl_in), .cnt_out_r(cnt_out_r), .live_count_r(live_count_r),
    .hold_active_r(hold_active_r));
`default_nettype wire

// ### test/c16_host.sv
// serial bus host model that reaches the counter registers
`timescale 1ns/1ps
`default_nettype none
module c16_host #(
    parameter logic [6:0] TARGET = 7'h08
) (
    // clock
    input wire logic core_clk,
    // serial bus, open drain resolved by the bench
    input wire logic sda_line,
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'h1;
        sda = 1'h1;
    end
    // ================================================================
    // bus steps; 5 clocks per half period stays above the 4-clock minimum
    task automatic step(input logic c, input logic d);
        @(posedge core_clk);
        scl <= c;
        sda <= d;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            step(1'h0, d[i]);
            step(1'h1, d[i]);
            q[i] = sda_line;
        end
        step(1'h0, ack);
        step(1'h1, ack);
    endtask
    task automatic start();
        step(1'h0, 1'h1);
        step(1'h1, 1'h1);
        step(1'h1, 1'h0);
        step(1'h0, 1'h0);
    endtask
    task automatic stop();
        step(1'h0, 1'h0);
        step(1'h1, 1'h0);
        step(1'h1, 1'h1);
    endtask
    // ================================================================
    // register accesses; counting may go on meanwhile
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        start();
        xfer({TARGET, 1'h0}, 1'h1, q);
        xfer(a, 1'h1, q);
        xfer(d, 1'h1, q);
        stop();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] q;
        start();
        xfer({TARGET, 1'h0}, 1'h1, q);
        xfer(a, 1'h1, q);
        start();
        xfer({TARGET, 1'h1}, 1'h1, q);
        xfer(8'hFF, 1'h1, d);
        stop();
    endtask
endmodule
`default_nettype wire

// ### test/test_counter16_serial_reload_access.sv
// self-checking bench for the serial-reload 16-bit counter
`timescale 1ns/1ps
`default_nettype none
module test_counter16_serial_reload_access;
    localparam int HB = 4;
    logic core_clk, reset, cnt_clk_in, cnt_set, cnt_reset, count_up, hold_enable;
    wire scl, h_sda, sda_out, sda_oe, cnt_out_r, hold_active_r;
    wire [15:0] live_count_r;
    // pulled-up line: low while either side pulls
    wire sda_line = h_sda & (~sda_oe | sda_out);
    int num_errors = 0;
    int num_checks = 0;
    int pulses = 0;
    int hold_cyc = 0;
    int np, nh;
    logic done;
    logic [7:0] rb;
    logic [15:0] rl, nv, exp_c;
    c16_counter #(.HOLD_BITS(HB)) DUT (
        .core_clk(core_clk), .reset(reset), .cnt_clk_in(cnt_clk_in), .cnt_set(cnt_set),
        .cnt_reset(cnt_reset), .count_up(count_up), .hold_enable(hold_enable),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .cnt_out_r(cnt_out_r), .live_count_r(live_count_r), .hold_active_r(hold_active_r));
    c16_host h (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda(h_sda));
    initial begin
        core_clk = 1'h0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (cnt_out_r === 1'h1) pulses <= pulses + 1;
        if (hold_active_r === 1'h1) hold_cyc <= hold_cyc + 1;
    end
    // ================================================================
    // helpers
    function automatic logic [15:0] next_down(input logic [15:0] c, input logic [15:0] r);
        return (c == 16'h0000) ? r : c - 16'h0001;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge core_clk) cnt_clk_in <= 1'h1;
        repeat (4) @(posedge core_clk);
        cnt_clk_in <= 1'h0;
        repeat (4) @(posedge core_clk);
    endtask
    // counts down to the next underflow, checking each step
    task automatic drain(input logic [15:0] r);
        for (int i = 0; i < 300; i++) begin
            done = (exp_c == 16'h0000);
            tick();
            exp_c = next_down(exp_c, r);
            chk(live_count_r, exp_c);
            if (done) break;
        end
        if (!done) begin
            num_errors++;
            $display("wrong value at %0t: no underflow within the tick limit", $time);
            summarize();
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #2ms;
        num_errors++;
        summarize();
    end
    // ================================================================
    // main sequence
    initial begin
        {cnt_clk_in, cnt_set, cnt_reset, count_up, hold_enable} = 5'h00;
        reset = 1'h1;
        void'($urandom(71));
        repeat (3) @(posedge core_clk);
        reset <= 1'h0;
        rl = 16'($urandom);
        h.wr(8'hC5, rl[7:0]);
        h.wr(8'hC6, rl[15:8]);
        h.rd(8'hC5, rb);
        chk(rb, rl[7:0]);
        h.rd(8'hC6, rb);
        chk(rb, rl[15:8]);
        @(posedge core_clk) cnt_set <= 1'h1;
        @(posedge core_clk) cnt_set <= 1'h0;
        repeat (3) @(posedge core_clk);
        chk(live_count_r, rl);
        h.wr(8'hEB, ~rl[7:0]);
        h.rd(8'hEB, rb);
        chk(rb, rl[7:0]);
        h.rd(8'hEC, rb);
        chk(rb, rl[15:8]);
        h.rd(8'h10, rb);
        chk(rb, 8'h00);
        // small reload, run through two underflows
        rl = 16'($urandom_range(9, 3));
        h.wr(8'hC5, rl[7:0]);
        h.wr(8'hC6, 8'h00);
        // start from zero so the first underflow is near
        @(posedge core_clk) cnt_reset <= 1'h1;
        @(posedge core_clk) cnt_reset <= 1'h0;
        exp_c = 16'h0000;
        np = pulses;
        drain(16'h0000 + rl);
        chk(live_count_r, rl);
        drain(rl);
        chk(16'(pulses - np - 1), 16'h0001);
        // low byte only, written while counting goes on
        nv = {8'($urandom_range(255, 1)), 8'($urandom_range(6, 2))};
        fork
            h.wr(8'hC5, nv[7:0]);
            repeat (3) begin
                repeat (80) @(posedge core_clk);
                tick();
            end
        join
        exp_c = exp_c - 16'h0003;
        chk(live_count_r, exp_c);
        drain({8'h00, nv[7:0]});
        h.wr(8'hC6, nv[15:8]);
        drain(nv);
        // clock hold on reload addresses only
        @(posedge core_clk) hold_enable <= 1'h1;
        nh = hold_cyc;
        h.wr(8'hEB, 8'h00);
        chk(16'(hold_cyc - nh), 16'h0000);
        fork
            h.wr(8'hC5, nv[7:0]);
            repeat (40) tick();
        join
        chk(16'(hold_cyc > nh), 16'h0001);
        chk(16'(live_count_r > nv - 16'h0028 && live_count_r <= nv), 16'h0001);
        nh = hold_cyc;
        h.rd(8'hC6, rb);
        chk(rb, nv[15:8]);
        chk(16'(hold_cyc - nh >= 25 && hold_cyc - nh <= 55), 16'h0001);
        // falling counter clock while reload data returns
        @(posedge core_clk) count_up <= 1'h1;
        h.wr(8'hC5, 8'h00);
        h.wr(8'hC6, 8'h80);
        @(posedge core_clk) cnt_reset <= 1'h1;
        @(posedge core_clk) cnt_reset <= 1'h0;
        fork
            h.rd(8'hC5, rb);
            repeat (45) tick();
        join
        chk(rb, 8'h00);
        tick();
        tick();
        chk(16'(live_count_r >= 16'h8000 && live_count_r < 16'h8040), 16'h0001);
        summarize();
    end
endmodule
`default_nettype wire
